/* File: core/axsw_pkg.sv */
// axsw_pkg: shared types and constants of the two-to-one stream packet switch
// assumes nothing of its surroundings; imported by scoped name only
package axsw_pkg;
    // documented instance widths
    localparam int DATA_W_DEF    = 512;
    localparam int USER_W_MAC    = 1;
    localparam int USER_W_DMA    = 81;
    // documented clock rates of the two instances, in MHz
    localparam int MAC_CLK_MHZ   = 300;
    localparam int DMA_CLK_MHZ   = 250;
    // reset values
    localparam logic RST_CHAN    = 1'h0;
    localparam logic RST_VALID   = 1'h0;
    // skid buffer depth in words
    localparam int SKID_DEPTH    = 2;

    // arbiter states
    typedef enum logic [0:0] {
        AXSW_IDLE = 1'h0,
        AXSW_PKT  = 1'h1
    } axsw_state_e;

    // one beat with its sideband, at the documented default widths
    typedef struct packed {
        logic [DATA_W_DEF-1:0] data;
        logic [USER_W_MAC-1:0] user;
        logic                  last;
    } axsw_beat_s;
endpackage

/* File: core/axsw_skid.sv */
// axsw_skid: two-entry register buffer with valid/ready on both sides
// assumes one clock, asynchronous active-high reset; read data come from flops
`timescale 1ns/1ns
module axsw_skid #(
    parameter int WIDTH = 514
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_word_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_word_o
);
    initial begin
        if (WIDTH < 1) $error("axsw_skid: WIDTH must be positive");
    end

    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] next_head;
    logic [WIDTH-1:0] spare;
    logic [WIDTH-1:0] next_spare;
    logic [1:0]       count;
    logic [1:0]       next_count;
    logic             push;
    logic             pop;

    // ready only while a slot is free, so back-pressure reaches the source
    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_word_o  = head;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // next head, spare and fill count
    always_comb begin
        next_head  = head;
        next_spare = spare;
        next_count = count;
        unique case ({push, pop})
            2'b10: begin
                if (count == 2'h0) next_head = in_word_i;
                else next_spare = in_word_i;
                next_count = count + 2'h1;
            end
            2'b01: begin
                next_head  = spare;
                next_count = count - 2'h1;
            end
            2'b11: begin
                if (count == 2'h1) next_head = in_word_i;
                else begin
                    next_head  = spare;
                    next_spare = in_word_i;
                end
            end
            default: begin
            end
        endcase
    end

    // register state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            head  <= '0;
            spare <= '0;
            count <= 2'h0;
        end else begin
            head  <= next_head;
            spare <= next_spare;
            count <= next_count;
        end
    end
endmodule

/* File: core/axsw_switch.sv */
// axsw_switch: two-input, one-output stream switch granting whole packets
// assumes masters hold beats stable while not ready; one clock domain
`timescale 1ns/1ns

// Functional notes
// - simultaneous requests: grant priority channel, whole packet
// - after packet end, priority moves to other channel if it is valid
// - data and user widths are parameters
// - idle dual request keeps selector, readies it
// - registered data/last drive output with valid
// - output stall holds outputs, drops input ready once latch is full
// - accepted beats land in latch, none lost
// - after last beat, switch if other valid
// - single clock domain, no internal crossing
module axsw_switch #(
    parameter int DATA_W = axsw_pkg::DATA_W_DEF,
    parameter int USER_W = axsw_pkg::USER_W_MAC
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [1:0]        input_valid_i,
    output logic      [1:0]        input_ready_o,
    input  wire logic [1:0]        input_last_i,
    input  wire logic [DATA_W-1:0] input_data0_i,
    input  wire logic [DATA_W-1:0] input_data1_i,
    input  wire logic [USER_W-1:0] input_user0_i,
    input  wire logic [USER_W-1:0] input_user1_i,
    output logic                   output_valid_o,
    input  wire logic              output_ready_i,
    output logic                   output_last_o,
    output logic      [DATA_W-1:0] output_data_o,
    output logic      [USER_W-1:0] output_user_o,
    output logic                   active_channel_select_o
);
    localparam int WORD_W = DATA_W + USER_W + 1;

    // widths checked at simulation start
    initial begin
        if (DATA_W < 8) $error("axsw_switch: DATA_W too small");
        if (USER_W < 1) $error("axsw_switch: USER_W must be positive");
    end

    axsw_pkg::axsw_state_e state;
    axsw_pkg::axsw_state_e next_state;
    logic                  active_channel_select;
    logic                  next_active_channel_select;
    logic                  skid_in_ready;
    logic                  sel_valid;
    logic                  sel_last;
    logic                  take;
    logic [WORD_W-1:0]     sel_word;
    logic [WORD_W-1:0]     out_word;

    // mux of the granted channel; one clock, no crossing anywhere
    always_comb begin
        if (active_channel_select) begin
            sel_valid = input_valid_i[1];
            sel_last  = input_last_i[1];
            sel_word  = {input_data1_i, input_user1_i, input_last_i[1]};
        end else begin
            sel_valid = input_valid_i[0];
            sel_last  = input_last_i[0];
            sel_word  = {input_data0_i, input_user0_i, input_last_i[0]};
        end
    end

    // ready only toward the granted channel, dropped when the latch is full
    // and held low while reset stands so no master sees a false accept
    always_comb begin
        input_ready_o = 2'b00;
        input_ready_o[active_channel_select] = skid_in_ready && !rst_i;
    end
    assign take = sel_valid && skid_in_ready;

    // packet arbitration: hold grant to last beat, then offer the other side
    always_comb begin
        next_state                 = state;
        next_active_channel_select = active_channel_select;
        unique case (state)
            axsw_pkg::AXSW_IDLE: begin
                if (take && !sel_last) begin
                    next_state = axsw_pkg::AXSW_PKT;
                end else if (take && sel_last) begin
                    if (input_valid_i[~active_channel_select]) begin
                        next_active_channel_select = ~active_channel_select;
                    end
                end else if (!sel_valid && input_valid_i[~active_channel_select]) begin
                    next_active_channel_select = ~active_channel_select;
                end
            end
            axsw_pkg::AXSW_PKT: begin
                if (take && sel_last) begin
                    next_state = axsw_pkg::AXSW_IDLE;
                    if (input_valid_i[~active_channel_select]) begin
                        next_active_channel_select = ~active_channel_select;
                    end
                end
            end
        endcase
    end

    // arbitration registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state                 <= axsw_pkg::AXSW_IDLE;
            active_channel_select <= axsw_pkg::RST_CHAN;
        end else begin
            state                 <= next_state;
            active_channel_select <= next_active_channel_select;
        end
    end

    // output skid latch: accepted beats held until the slave takes them
    axsw_skid #(
        .WIDTH(WORD_W)
    ) u_output_skid_latch (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .in_valid_i (sel_valid),
        .in_ready_o (skid_in_ready),
        .in_word_i  (sel_word),
        .out_valid_o(output_valid_o),
        .out_ready_i(output_ready_i),
        .out_word_o (out_word)
    );

    // registered output fields
    assign output_data_o           = out_word[WORD_W-1 -: DATA_W];
    assign output_user_o           = out_word[USER_W:1];
    assign output_last_o           = out_word[0];
    assign active_channel_select_o = active_channel_select;
endmodule

/* File: dv/axsw_switch_checker.sv */
// checker: port relations of the stream packet switch
// assumes it is bound into axsw_switch; one clock, async reset
`timescale 1ns/1ns
module axsw_switch_checker #(parameter int DATA_W = 8, parameter int USER_W = 1) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [1:0]        input_valid_i,
    input wire logic [1:0]        input_ready_o,
    input wire logic [1:0]        input_last_i,
    input wire logic [DATA_W-1:0] input_data0_i,
    input wire logic [DATA_W-1:0] input_data1_i,
    input wire logic              output_valid_o,
    input wire logic              output_ready_i,
    input wire logic              output_last_o,
    input wire logic [DATA_W-1:0] output_data_o,
    input wire logic [USER_W-1:0] output_user_o,
    input wire logic              active_channel_select_o
);
    logic              sel, acc, lst, mid, next_mid;
    logic [DATA_W-1:0] din;
    // beat taken on the granted channel
    assign sel = active_channel_select_o;
    assign acc = input_valid_i[sel] && input_ready_o[sel];
    assign lst = input_last_i[sel];
    assign din = sel ? input_data1_i : input_data0_i;
    // high between first and last beat of a packet
    always_comb next_mid = acc ? !lst : mid;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) mid <= 1'h0;
        else mid <= next_mid;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reset_idle_a: assert property ($fell(rst_i) |-> !output_valid_o && !sel)
        else $error("not idle after reset");
    hold_stall_a: assert property (output_valid_o && !output_ready_i |=> output_valid_o
        && $stable({output_data_o, output_last_o, output_user_o})) else $error("stall moved");
    full_drop_a: assert property (output_valid_o && !output_ready_i && acc
        |=> input_ready_o == 2'h0) else $error("ready kept while full");
    other_off_a: assert property (!input_ready_o[!sel]) else $error("ungranted ready");
    grant_hold_a: assert property (mid && !(acc && lst) |=> $stable(sel))
        else $error("grant moved mid packet");
    keep_sel_a: assert property (!mid && &input_valid_i && !(acc && lst) |=> $stable(sel))
        else $error("idle grant moved");
    ready_sel_a: assert property (!mid && &input_valid_i && !output_valid_o
        |-> input_ready_o[sel]) else $error("granted not ready");
    first_beat_a: assert property (!output_valid_o && acc |=> output_valid_o
        && output_data_o == $past(din) && output_last_o == $past(lst)) else $error("bad beat");
    turn_over_a: assert property (acc && lst && input_valid_i[!sel]
        |=> sel != $past(sel)) else $error("no turn");
    cover property (acc && lst && input_valid_i[!sel]);
    cover property (output_valid_o && !output_ready_i && acc);
    cover property (!mid && &input_valid_i);
endmodule
bind axsw_switch axsw_switch_checker #(.DATA_W(DATA_W), .USER_W(USER_W)) u_chk (.*);

/* File: dv/axsw_sink.sv */
// axsw_sink: downstream stream slave that stalls on command
// assumes stall_i is set between edges by the bench
`timescale 1ns/1ns
module axsw_sink (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic stall_i,
    output logic      ready_o
);
    // ready moves only off the sampling edge
    always @(negedge clk_i or posedge rst_i)
        if (rst_i) ready_o <= 1'h0;
        else ready_o <= !stall_i;
endmodule

/* File: dv/axsw_switch_bench.sv */
// axsw_switch_bench: grant order, stall and turn-taking scenarios
// assumes switch, checker bind and sink model compiled before it
`timescale 1ns/1ns
module axsw_switch_bench;
    localparam int DW = 8;
    localparam int UW = axsw_pkg::USER_W_DMA;
    logic          clk_i = 1'h0, rst_i = 1'h1, stall = 1'h0, stall_en = 1'h0, output_ready_i;
    logic [1:0]    input_valid_i = 2'h0, input_last_i = 2'h0, input_ready_o, took = 2'h0;
    logic [DW-1:0] input_data0_i = 8'h00, input_data1_i = 8'h00, output_data_o;
    logic [UW-1:0] input_user0_i, input_user1_i, output_user_o;
    logic          output_valid_o, output_last_o, active_channel_select_o;
    logic [8:0]    q0[$], q1[$], exp_q[$], got[$];
    int            error_cnt = 0, n_checks = 0, cyc = 0;
    axsw_switch #(.DATA_W(DW), .USER_W(UW)) u_dut (.*);
    axsw_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_o(output_ready_i));
    always #2 clk_i = !clk_i;
    // sideband follows data so it can be traced through
    assign input_user0_i = {UW{input_data0_i[0]}};
    assign input_user1_i = {UW{input_data1_i[0]}};
    // output monitor, input acceptance and cycle ceiling
    always @(posedge clk_i) begin
        took <= input_valid_i & input_ready_o;
        cyc <= cyc + 1;
        if (output_valid_o && output_ready_i) begin
            got.push_back({output_last_o, output_data_o});
            check(UW'(output_user_o), UW'({UW{output_data_o[0]}}));
        end
        if (cyc == 2000) begin
            error_cnt++;
            final_report();
        end
    end
    // masters hold a beat until taken; idle data is scrambled
    always @(negedge clk_i) begin
        if (took[0]) void'(q0.pop_front());
        if (took[1]) void'(q1.pop_front());
        input_valid_i <= {q1.size() > 0, q0.size() > 0};
        input_last_i <= {q1.size() > 0 && q1[0][8], q0.size() > 0 && q0[0][8]};
        input_data0_i <= q0.size() > 0 ? q0[0][7:0] : ~input_data0_i;
        input_data1_i <= q1.size() > 0 ? q1[0][7:0] : ~input_data1_i;
        stall <= stall_en && cyc[1];
    end
    task automatic check(input logic [UW-1:0] seen, input logic [UW-1:0] want);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    // queue an n-beat packet on channel c and expect it at the output
    task automatic load(input int c, input int n);
        logic [8:0] b;
        for (int i = 0; i < n; i++) begin
            b = {1'(i == n - 1), 1'(c), 7'(i)};
            if (c == 1) q1.push_back(b);
            else q0.push_back(b);
            exp_q.push_back(b);
        end
    endtask
    // wait for all expected beats, then compare count and order
    task automatic drain();
        while (got.size() < exp_q.size()) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        check(UW'(got.size()), UW'(exp_q.size()));
        foreach (exp_q[i]) check(UW'(got[i]), UW'(exp_q[i]));
        got.delete();
        exp_q.delete();
    endtask
    task automatic t_reset();
        @(negedge clk_i);
        check(UW'(output_valid_o), UW'(0));
        check(UW'(active_channel_select_o), UW'(0));
    endtask
    // both channels at once with a stalling slave
    task automatic t_dual();
        @(posedge clk_i);
        stall_en = 1'h1;
        load(0, 3);
        load(1, 2);
        drain();
        stall_en = 1'h0;
    endtask
    // grant rests on channel 1, then a one-beat packet on channel 0
    task automatic t_turn();
        @(posedge clk_i);
        check(UW'(active_channel_select_o), UW'(1));
        load(1, 2);
        load(0, 1);
        drain();
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        check(UW'(input_ready_o), UW'(0));
        rst_i <= 1'h0;
        t_reset();
        t_dual();
        t_turn();
        final_report();
    end
endmodule
